/* core/timer_defs.svh */
// Operation
// (RULE1) reset and low power zero the flags
// (RULE2) software writes of 1 never set flags
// (RULE3) zero write clears only after reading 1
// (RULE4) capture on input A sets bit 7
// (RULE5) buffered A moves old A into C
// (RULE6) capture on input B sets bit 6
// (RULE7) input C sets bit 5, even buffered
// (RULE8) input D sets bit 4, even buffered
// (RULE9) buffered C and D flags raise interrupts
// (RULE10) counter equals compare A sets bit 3
// (RULE11) counter equals compare B sets bit 2
// (RULE12) counter wrap to zero sets bit 1
// (RULE13) bit 0 clears counter on match A
// (RULE14) interrupt while flag and enable high
// (RULE15) buffered B moves old B into D
// (RULE16) capture loads regardless of flag state
// (RULE17) hardware set beats software clear
// (RULE18) per-flag read-as-one tracking gates clearing
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_STATUS 8'h00
`define OFS_CONTROL 8'h04
`define OFS_IRQ_EN 8'h08
`define OFS_COUNTER 8'h0C
`define OFS_CMP_A 8'h10
`define OFS_CMP_B 8'h14
`define OFS_CAP_A 8'h18
`define OFS_CAP_B 8'h1C
`define OFS_CAP_C 8'h20
`define OFS_CAP_D 8'h24
// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_CAP_A 7
`define BIT_CAP_B 6
`define BIT_CAP_C 5
`define BIT_CAP_D 4
`define BIT_CMP_A 3
`define BIT_CMP_B 2
`define BIT_WRAP 1
`define BIT_CLR_MATCH 0
`define BIT_BUF_A 3
`define BIT_BUF_B 2
// ----------------------------------------
// reset values and counter maximum
// ----------------------------------------
`define STATUS_RST 8'h00
`define CONTROL_RST 8'h00
`define IRQ_EN_RST 7'h00
`define CMP_RST 16'hFFFF
`define CAP_RST 16'h0000
`define CNT_MAX 16'hFFFF
// ----------------------------------------
// prescaler counts
// ----------------------------------------
`define DIV_2 5'd1
`define DIV_8 5'd7
`define DIV_32 5'd31
`endif

/* core/timer_pkg.sv */
package timer_pkg;
  // read channel sequencing
  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_DATA = 1'b1
  } rd_state_t;
  // counter clock selection
  typedef enum logic [1:0] {
    CKS_DIV2 = 2'b00,
    CKS_DIV8 = 2'b01,
    CKS_DIV32 = 2'b10,
    CKS_EXT = 2'b11
  } clk_sel_t;
  // one 16-bit timer word
  typedef logic [15:0] word16_t;
endpackage : timer_pkg

/* core/timer_evt_if.sv */
`timescale 1ns/1ps
// hardware flag-set events, capture side to flag side
interface timer_evt_if;
  logic [7:1] set_vec;
  modport cap (output set_vec);
  modport flg (input set_vec);
endinterface : timer_evt_if

/* core/timer_flag_unit.sv */
`timescale 1ns/1ps
`include "timer_defs.svh"
module timer_flag_unit
  import timer_pkg::*;
(
  // clock and init
  input wire logic clk,
  input wire logic init,
  // events
  timer_evt_if.flg evt,
  // software access
  input wire logic status_rd,
  input wire logic status_wr,
  input wire logic [7:0] wr_byte,
  // state
  output logic [7:0] status
);
  logic [7:1] flag_q; // event flags
  logic [7:1] seen_q; // flag was read as 1
  logic clr_match_q; // counter clear on match a
  logic [7:1] clr_ok; // valid clearing write per flag

  // ----------------------------------------
  // clear qualification
  // ----------------------------------------
  // (RULE3) needs read of one
  // (RULE2) ones are ignored
  assign clr_ok = {7{status_wr}} & ~wr_byte[7:1] & seen_q;

  // flags: set has priority over clear
  always_ff @(posedge clk) begin
    // (RULE1) init to zero
    if (init) begin
      flag_q <= '0;
    end else begin
      // (RULE17) set wins clear
      flag_q <= evt.set_vec | (flag_q & ~clr_ok);
    end
  end

  // read-as-one tracking, cleared on every set
  always_ff @(posedge clk) begin
    if (init) begin
      seen_q <= '0;
    end else begin
      // (RULE18) per flag tracking
      seen_q <= (seen_q | ({7{status_rd}} & flag_q))
                & ~evt.set_vec & ~clr_ok;
    end
  end

  // ordinary read/write control bit
  always_ff @(posedge clk) begin
    if (init) begin
      clr_match_q <= 1'b0;
    end else if (status_wr) begin
      // (RULE13) plain rw bit
      clr_match_q <= wr_byte[`BIT_CLR_MATCH];
    end
  end

  assign status = {flag_q, clr_match_q};
endmodule : timer_flag_unit

/* core/timer_capture_unit.sv */
`timescale 1ns/1ps
`include "timer_defs.svh"
module timer_capture_unit
  import timer_pkg::*;
(
  // clock and init
  input wire logic clk,
  input wire logic init,
  // capture pins, asynchronous
  input wire logic [3:0] capture_in,
  // configuration
  input wire logic [3:0] edge_sel,
  input wire logic buffer_enable_a,
  input wire logic buffer_enable_b,
  input wire clk_sel_t clk_sel,
  input wire logic clear_on_match_a,
  input wire word16_t compare_reg_a,
  input wire word16_t compare_reg_b,
  // counter write
  input wire logic cnt_wr,
  input wire word16_t cnt_wdata,
  // state
  output word16_t free_running_counter,
  output word16_t capture_reg_a,
  output word16_t capture_reg_b,
  output word16_t capture_reg_c,
  output word16_t capture_reg_d,
  // events
  timer_evt_if.cap evt
);
  logic [3:0] sync1_q, sync2_q, prev_q; // pin synchroniser
  logic [3:0] rise, fall, ev; // edges per pin
  logic ev_a, ev_b; // channel a/b capture events
  logic [4:0] div_q, div_lim; // prescaler
  logic tick, match_a, match_b, wrap;

  // two flops before any logic sees a pin
  always_ff @(posedge clk) begin
    sync1_q <= capture_in;
    sync2_q <= sync1_q;
    prev_q <= sync2_q;
  end

  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;
  assign ev = (edge_sel & rise) | (~edge_sel & fall);
  // buffered pair: differing selects capture both edges
  assign ev_a = buffer_enable_a
      ? (((edge_sel[3] | edge_sel[1]) & rise[3]) |
         (~(edge_sel[3] & edge_sel[1]) & fall[3]))
      : ev[3];
  assign ev_b = buffer_enable_b
      ? (((edge_sel[2] | edge_sel[0]) & rise[2]) |
         (~(edge_sel[2] & edge_sel[0]) & fall[2]))
      : ev[2];

  // prescaler limit; external source keeps counter still
  always_comb begin
    case (clk_sel)
      CKS_DIV2: div_lim = `DIV_2;
      CKS_DIV8: div_lim = `DIV_8;
      default: div_lim = `DIV_32;
    endcase
  end

  always_ff @(posedge clk) begin
    if (init || div_q >= div_lim) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 5'd1;
    end
  end

  assign tick = (div_q == div_lim) && (clk_sel != CKS_EXT);
  assign match_a = tick && free_running_counter == compare_reg_a;
  assign match_b = tick && free_running_counter == compare_reg_b;
  // a clear by match a is not counted as a wrap
  assign wrap = tick && free_running_counter == `CNT_MAX
      && !(match_a && clear_on_match_a);

  // counter: software write, match clear, increment
  always_ff @(posedge clk) begin
    if (init) begin
      free_running_counter <= '0;
    end else if (cnt_wr) begin
      free_running_counter <= cnt_wdata;
    end else if (match_a && clear_on_match_a) begin
      // (RULE13) clear on match
      free_running_counter <= '0;
    end else if (tick) begin
      free_running_counter <= free_running_counter + 16'h0001;
    end
  end

  // capture a and b, loaded whatever the flags hold
  always_ff @(posedge clk) begin
    if (init) begin
      capture_reg_a <= `CAP_RST;
      capture_reg_b <= `CAP_RST;
    end else begin
      // (RULE16) load regardless flag
      if (ev_a) begin
        capture_reg_a <= free_running_counter;
      end
      if (ev_b) begin
        capture_reg_b <= free_running_counter;
      end
    end
  end

  // capture c and d, or buffers of a and b
  always_ff @(posedge clk) begin
    if (init) begin
      capture_reg_c <= `CAP_RST;
      capture_reg_d <= `CAP_RST;
    end else begin
      // (RULE5) buffer a into c
      if (buffer_enable_a) begin
        if (ev_a) begin
          capture_reg_c <= capture_reg_a;
        end
      end else if (ev[1]) begin
        capture_reg_c <= free_running_counter;
      end
      // (RULE15) buffer b into d
      if (buffer_enable_b) begin
        if (ev_b) begin
          capture_reg_d <= capture_reg_b;
        end
      end else if (ev[0]) begin
        capture_reg_d <= free_running_counter;
      end
    end
  end

  // (RULE4) capture a flag
  assign evt.set_vec[`BIT_CAP_A] = ev_a;
  // (RULE6) capture b flag
  assign evt.set_vec[`BIT_CAP_B] = ev_b;
  // (RULE7) c flag always set
  assign evt.set_vec[`BIT_CAP_C] = ev[1];
  // (RULE8) d flag always set
  assign evt.set_vec[`BIT_CAP_D] = ev[0];
  // (RULE10) compare a flag
  assign evt.set_vec[`BIT_CMP_A] = match_a;
  // (RULE11) compare b flag
  assign evt.set_vec[`BIT_CMP_B] = match_b;
  // (RULE12) wrap flag
  assign evt.set_vec[`BIT_WRAP] = wrap;
endmodule : timer_capture_unit

/* core/timer_event_status_top.sv */
`timescale 1ns/1ps
`include "timer_defs.svh"
module timer_event_status_top
  import timer_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // low power entry, same clock domain
  input wire logic low_power_enter,
  // capture pins
  input wire logic [3:0] capture_in,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // interrupt requests, one per flag
  output logic [7:1] irq_req
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  logic init; // reset or low power entry
  // write channel holding state
  logic [ADDR_W-1:0] aw_addr_q; // latched write address
  logic [31:0] w_data_q; // latched write data
  logic [3:0] w_strb_q; // latched byte enables
  logic do_write; // both halves held, perform
  logic wr_hit; // write address decoded
  // read channel
  rd_state_t rd_state_q; // read sequencer
  logic rd_take; // read address handshake
  logic [31:0] rd_word; // decoded read word
  logic rd_hit; // read address decoded
  // software registers
  logic [7:0] timer_control_q; // edges, buffers, clock
  logic [7:1] irq_enable_q; // per flag enables
  word16_t compare_reg_a_q; // compare a
  word16_t compare_reg_b_q; // compare b
  // capture unit results
  word16_t free_running_counter;
  word16_t capture_reg_a, capture_reg_b;
  word16_t capture_reg_c, capture_reg_d;
  // status path
  logic [7:0] timer_event_status;
  logic status_rd, status_wr, cnt_wr;

  timer_evt_if evt_bus ();

  assign init = reset | low_power_enter;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // merge byte lanes of a 16-bit register
  function automatic word16_t merge16(
    input word16_t old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    word16_t res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : merge16

  // true when an address names a register
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] ofs;
    ofs = a[7:0];
    return (ofs[1:0] == 2'b00) && (ofs <= `OFS_CAP_D);
  endfunction : mapped

  // ----------------------------------------
  // write address channel
  // ----------------------------------------
  // ready drops once an address is held, back after b
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_addr_q <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // ----------------------------------------
  // write data channel
  // ----------------------------------------
  // data may arrive before, with or after the address
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_wready <= 1'b1;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // one write at a time: performed exactly once
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_hit = mapped(aw_addr_q);

  // ----------------------------------------
  // write response channel
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      // unmapped addresses answer slave error
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // write side effects
  // ----------------------------------------
  // status and counter writes are pulses to the units
  assign status_wr = do_write && w_strb_q[0]
      && aw_addr_q[7:0] == `OFS_STATUS;
  assign cnt_wr = do_write && (w_strb_q[1:0] != 2'b00)
      && aw_addr_q[7:0] == `OFS_COUNTER;

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  // control and enables, cleared by low power too
  always_ff @(posedge clk) begin
    if (init) begin
      timer_control_q <= `CONTROL_RST;
      irq_enable_q <= `IRQ_EN_RST;
    end else if (do_write && w_strb_q[0]) begin
      // address decode for byte-wide registers
      if (aw_addr_q[7:0] == `OFS_CONTROL) begin
        timer_control_q <= w_data_q[7:0];
      end else if (aw_addr_q[7:0] == `OFS_IRQ_EN) begin
        irq_enable_q <= w_data_q[7:1];
      end
    end
  end

  // compare registers start at all ones
  always_ff @(posedge clk) begin
    if (init) begin
      compare_reg_a_q <= `CMP_RST;
      compare_reg_b_q <= `CMP_RST;
    end else if (do_write) begin
      // address decode for compare words
      if (aw_addr_q[7:0] == `OFS_CMP_A) begin
        compare_reg_a_q <= merge16(compare_reg_a_q, w_data_q,
                                   w_strb_q);
      end else if (aw_addr_q[7:0] == `OFS_CMP_B) begin
        compare_reg_b_q <= merge16(compare_reg_b_q, w_data_q,
                                   w_strb_q);
      end
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_hit = mapped(s_axi_araddr);
  // reading status arms the clearing of flags seen as 1
  assign status_rd = rd_take && s_axi_araddr[7:0] == `OFS_STATUS;

  // read decode; reserved bits read as zero, except enable bit 0
  always_comb begin
    rd_word = '0;
    if (s_axi_araddr[7:0] == `OFS_STATUS) begin
      rd_word[7:0] = timer_event_status;
    end else if (s_axi_araddr[7:0] == `OFS_CONTROL) begin
      rd_word[7:0] = timer_control_q;
    end else if (s_axi_araddr[7:0] == `OFS_IRQ_EN) begin
      // lowest enable bit is reserved and reads as one
      rd_word[7:0] = {irq_enable_q, 1'b1};
    end else if (s_axi_araddr[7:0] == `OFS_COUNTER) begin
      rd_word[15:0] = free_running_counter;
    end else if (s_axi_araddr[7:0] == `OFS_CMP_A) begin
      rd_word[15:0] = compare_reg_a_q;
    end else if (s_axi_araddr[7:0] == `OFS_CMP_B) begin
      rd_word[15:0] = compare_reg_b_q;
    end else if (s_axi_araddr[7:0] == `OFS_CAP_A) begin
      rd_word[15:0] = capture_reg_a;
    end else if (s_axi_araddr[7:0] == `OFS_CAP_B) begin
      rd_word[15:0] = capture_reg_b;
    end else if (s_axi_araddr[7:0] == `OFS_CAP_C) begin
      rd_word[15:0] = capture_reg_c;
    end else if (s_axi_araddr[7:0] == `OFS_CAP_D) begin
      rd_word[15:0] = capture_reg_d;
    end
  end

  // read sequencer: data follows the address by one cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_state_q <= RD_IDLE;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      case (rd_state_q)
        RD_IDLE: begin
          if (rd_take) begin
            rd_state_q <= RD_DATA;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
          end
        end
        RD_DATA: begin
          // data held stable until the master takes it
          if (s_axi_rready) begin
            rd_state_q <= RD_IDLE;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
          end
        end
        default: begin
          rd_state_q <= RD_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // interrupt requests
  // ----------------------------------------
  // registered so the request follows the flag by a cycle
  always_ff @(posedge clk) begin
    if (init) begin
      irq_req <= '0;
    end else begin
      // (RULE14) flag and enable
      // (RULE9) c and d too
      irq_req <= timer_event_status[7:1] & irq_enable_q;
    end
  end

  // ----------------------------------------
  // units
  // ----------------------------------------
  // counter, captures and compares
  timer_capture_unit u_capture (
    .clk (clk),
    .init (init),
    .capture_in (capture_in),
    .edge_sel (timer_control_q[7:4]),
    .buffer_enable_a (timer_control_q[`BIT_BUF_A]),
    .buffer_enable_b (timer_control_q[`BIT_BUF_B]),
    .clk_sel (clk_sel_t'(timer_control_q[1:0])),
    .clear_on_match_a (timer_event_status[`BIT_CLR_MATCH]),
    .compare_reg_a (compare_reg_a_q),
    .compare_reg_b (compare_reg_b_q),
    .cnt_wr (cnt_wr),
    .cnt_wdata (merge16(free_running_counter, w_data_q, w_strb_q)),
    .free_running_counter (free_running_counter),
    .capture_reg_a (capture_reg_a),
    .capture_reg_b (capture_reg_b),
    .capture_reg_c (capture_reg_c),
    .capture_reg_d (capture_reg_d),
    .evt (evt_bus.cap)
  );

  // event flags with read-then-clear protocol
  timer_flag_unit u_flags (
    .clk (clk),
    .init (init),
    .evt (evt_bus.flg),
    .status_rd (status_rd),
    .status_wr (status_wr),
    .wr_byte (w_data_q[7:0]),
    .status (timer_event_status)
  );
endmodule : timer_event_status_top

/* sim/capture_pin_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// capture pin driver
// ----------------------------------------
module capture_pin_model (
  // clock
  input wire logic clk,
  // capture pins, idle low
  output logic [3:0] pins
);
  initial pins = 4'h0;
  // high for four clocks, then low four clocks so every edge is seen
  task pulse(input logic [3:0] m);
    @(posedge clk);
    pins <= pins | m;
    repeat (4) @(posedge clk);
    pins <= pins & ~m;
    repeat (4) @(posedge clk);
  endtask : pulse
endmodule : capture_pin_model

/* sim/timer_event_status_assertions.sv */
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module timer_event_status_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic low_power_enter,
  // write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // requests
  input wire logic [7:1] irq_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_reset_quiet: assert property ($fell(reset) |->
    irq_req == 7'h00 && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  a_sleep_clears: assert property (low_power_enter |->
    ##2 irq_req == 7'h00) else $error("request kept in low power");
  // a request only drops after a write or low power entry
  a_irq_fall_cause: assert property (
    (|($past(irq_req) & ~irq_req)) |-> $past(s_axi_bvalid) ||
    $past(low_power_enter) || $past(low_power_enter, 2))
    else $error("request dropped without cause");
  a_bresp_held: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  a_rdata_held: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_write_latency: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
    !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
  a_read_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_one_write: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("second write accepted");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_irq: cover property ($rose(|irq_req));
endmodule : timer_event_status_assertions
bind timer_event_status_top timer_event_status_assertions chk (.*);

/* sim/tb_timer_event_status_top.sv */
`timescale 1ns/1ps
module tb_timer_event_status_top;
  logic clk, reset, lp, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd, v;
  logic [1:0] bresp, rresp, r;
  logic [3:0] cap, ws;
  logic [2:0] prot;
  logic [7:1] irq;
  int n_mismatch = 0;
  int samples_checked = 0;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  capture_pin_model pins (.clk(clk), .pins(cap));
  timer_event_status_top dut (.clk(clk), .reset(reset),
    .low_power_enter(lp), .capture_in(cap), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(prot),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_arprot(prot), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
    .irq_req(irq));
  // ----------------------------------------
  // report
  // ----------------------------------------
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  task chk(input logic [33:0] g, input logic [33:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // ----------------------------------------
  // bus tasks, bounded waits
  // ----------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    br <= 1'b1;
    // each channel released at its own handshake
    do begin
      @(posedge clk);
      n++;
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv && n < 40);
    r = bresp;
    br <= 1'b0;
    if (n >= 40) begin
      n_mismatch++;
      complete_run();
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arr) arv <= 1'b0;
    end while (!rv && n < 40);
    v = rd;
    r = rresp;
    rr <= 1'b0;
    if (n >= 40) begin
      n_mismatch++;
      complete_run();
    end
  endtask : axi_rd
  task rchk(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a);
    chk({r, v}, {2'b00, e});
  endtask : rchk
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {reset, lp, awv, wv, br, arv, rr} = 7'h7f & 7'h40;
    {awa, ara, wd} = 48'h0;
    prot = 3'h0;
    ws = 4'hf;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rchk(8'h00, 32'h0000_0000);
    rchk(8'h08, 32'h0000_0001);
    rchk(8'h10, 32'h0000_ffff);
    axi_rd(8'h03);
    chk(r, 2'b10);
    // unaligned write answers slave error
    axi_wr(8'h03, 32'h0000_0000);
    chk(r, 2'b10);
    // ones never set a flag, bit 0 is plain storage
    axi_wr(8'h00, 32'h0000_00ff);
    chk(r, 2'b00);
    rchk(8'h00, 32'h0000_0001);
    $display("test reset_and_write_ones done");
    // counter stopped so captured values are known
    axi_wr(8'h04, 32'h0000_00f3);
    axi_wr(8'h0c, 32'h0000_1234);
    axi_wr(8'h08, 32'h0000_00c0);
    pins.pulse(4'hc);
    chk(irq, 7'h60);
    axi_wr(8'h00, 32'h0000_0001);
    rchk(8'h00, 32'h0000_00c1);
    rchk(8'h18, 32'h0000_1234);
    rchk(8'h1c, 32'h0000_1234);
    axi_wr(8'h00, 32'h0000_0000);
    rchk(8'h00, 32'h0000_0000);
    chk(irq, 7'h00);
    $display("test capture_and_clear done");
    // buffered channels with both buffer enables set
    axi_wr(8'h04, 32'h0000_00ff);
    axi_wr(8'h0c, 32'h0000_0055);
    axi_wr(8'h08, 32'h0000_0030);
    pins.pulse(4'hb);
    chk(irq, 7'h18);
    rchk(8'h00, 32'h0000_00b0);
    rchk(8'h18, 32'h0000_0055);
    rchk(8'h20, 32'h0000_1234);
    rchk(8'h24, 32'h0000_0000);
    axi_wr(8'h0c, 32'h0000_0066);
    pins.pulse(4'h4);
    rchk(8'h1c, 32'h0000_0066);
    rchk(8'h24, 32'h0000_1234);
    $display("test buffered_capture done");
    // compare, wrap and clear on match, counter at clk/2
    axi_rd(8'h00);
    axi_wr(8'h00, 32'h0000_0000);
    axi_wr(8'h10, 32'h0000_0010);
    axi_wr(8'h14, 32'h0000_fff8);
    axi_wr(8'h0c, 32'h0000_fff0);
    axi_wr(8'h00, 32'h0000_0001);
    axi_wr(8'h04, 32'h0000_0000);
    repeat (150) @(posedge clk);
    rchk(8'h00, 32'h0000_000f);
    axi_rd(8'h0c);
    chk(v[15:0] > 16'h0010, 1'b0);
    $display("test compare_and_wrap done");
    // low power entry restores reset values
    lp <= 1'b1;
    @(posedge clk);
    lp <= 1'b0;
    rchk(8'h00, 32'h0000_0000);
    rchk(8'h04, 32'h0000_0000);
    rchk(8'h08, 32'h0000_0001);
    $display("test low_power done");
    // one byte lane only touches its own half
    ws <= 4'h2;
    axi_wr(8'h14, 32'h0000_1200);
    ws <= 4'hf;
    rchk(8'h14, 32'h0000_12ff);
    // 82 edges of counting after a zero load: /8 then /32
    axi_wr(8'h04, 32'h0000_0001);
    axi_wr(8'h0c, 32'h0000_0000);
    repeat (80) @(posedge clk);
    axi_rd(8'h0c);
    chk(v[15:0] >= 16'h000a && v[15:0] <= 16'h000b, 1'b1);
    axi_wr(8'h04, 32'h0000_0002);
    axi_wr(8'h0c, 32'h0000_0000);
    repeat (80) @(posedge clk);
    axi_rd(8'h0c);
    chk(v[15:0] >= 16'h0002 && v[15:0] <= 16'h0003, 1'b1);
    $display("test lanes_and_prescale done");
    complete_run();
  end
endmodule : tb_timer_event_status_top
